// file: hdl/csi_defines.vh
`ifndef CSI_DEFINES_VH
`define CSI_DEFINES_VH

// ****************************************
// data and address widths
// ****************************************
`define CSI_DATA_W 12
`define CSI_FIELD_W 3
`define CSI_GROUP_W 3
`define CSI_LINES 8

// ****************************************
// sense clear pulse timing
// ****************************************
`define CSI_CLEAR_NS 50
`define CSI_CLK_NS 10
`define CSI_CLEAR_CYC ((`CSI_CLEAR_NS + `CSI_CLK_NS - 1) / `CSI_CLK_NS)

// ****************************************
// field jumper reset value: all jumpers in selects field zero
// ****************************************
`define CSI_FIELD_JUMPERS 3'h0

// ****************************************
// apb register map
// ****************************************
`define CSI_REG_CTRL 12'h000
`define CSI_REG_STAT 12'h004
`define CSI_REG_DATA 12'h008
`define CSI_REG_ADDR 12'h00C
`define CSI_CTRL_FIELD_LSB 0
`define CSI_CTRL_LOCK_BIT 3
`define CSI_STAT_HIT_BIT 0
`define CSI_STAT_INH_BIT 1
`define CSI_STAT_CLR_BIT 2
`define CSI_STAT_DRV_BIT 3
`define CSI_STAT_LOCKOUT_BIT 4

`endif

// file: hdl/csi_line_decode.v
`timescale 1ns/1ps
`include "csi_defines.vh"

// ****************************************
// one address group to eight line selects, split in two decoder groups
// ****************************************
module csi_line_decode #(
	parameter GW = `CSI_GROUP_W,
	parameter NL = `CSI_LINES
) (
	input wire [GW-1:0] code,   // active-high address group
	input wire enable,          // line drive allowed
	output wire [NL-1:0] lines, // one-hot line selects
	output wire [NL/2-1:0] grp1, // first group outputs, codes 0..3
	output wire [NL/2-1:0] grp2  // second group outputs, codes 4..7
);
	genvar i;
	generate
		for (i = 0; i < NL; i = i + 1) begin : g_line
			// a genvar cannot be part-selected, so its code is held at group width
			localparam [GW-1:0] LINE_CODE = i;
			assign lines[i] = enable && (code == LINE_CODE); // R16
		end
	endgenerate
	assign grp1 = lines[NL/2-1:0]; // R16
	assign grp2 = lines[NL-1:NL/2]; // R16
endmodule

// file: hdl/csi_core.v
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "csi_defines.vh"

// Function
// [R01] sense flip-flops are cleared at the start of each read portion
// [R02] strobe with a sensed one sets that sense flip-flop, else it stays zero
// [R03] register drives data bus only while direction_n is low, otherwise undriven; the code also drives it in reset, as dir_n resets low
// [R04] processor holds direction_n low through write to restore the word read
// [R05] inhibit load gates take their bits from the memory data bus
// [R06] inhibit load enabled only with field hit and inhibit timing active
// [R07] an inhibit driver conducts only when a zero is to be stored
// [R08] field hit when extended address equals jumpers and rom space inactive
// [R09] all jumpers installed matches field zero
// [R10] load enable combines inhibit timing, return phase, field hit, write enable
// [R11] each access selects one x line and one y line from the address
// [R12] write line selection uses the same decoding as read selection
// [R13] bus data is loadable by processor registers or peripherals too
// [R14] sense clear only with write off and return on, about 50 ns long
// [R15] timing generator asserts inhibit only in the write portion
// [R16] each three-bit group decodes one-hot, codes 0-3 group one, 4-7 group two
module csi_core #(
	parameter DW = `CSI_DATA_W,
	parameter CLEAR_CYC = `CSI_CLEAR_CYC
) (
	input wire CLK,                      // 100 mhz clock
	input wire RESETN,                   // async reset, active low
	input wire [11:0] PADDR,             // apb address
	input wire PSEL,                     // apb select
	input wire PENABLE,                  // apb access phase
	input wire PWRITE,                   // apb direction
	input wire [31:0] PWDATA,            // apb write data
	output wire [31:0] PRDATA,           // apb read data
	output wire PREADY,                  // apb ready
	output wire PSLVERR,                 // apb error
	input wire [2:0] EXT_ADDR_N,         // extended address bits, active low
	input wire ROM_SPACE_N,              // rom space, active low
	input wire [11:0] MEM_ADDR_N,        // memory address register, active low
	input wire RETURN_PHASE,             // return phase from timing
	input wire WRITE_ACTIVE,             // write portion of cycle
	input wire WRITE_EN,                 // write enable from read/write control
	input wire INHIBIT_TIME,             // inhibit timing signal
	input wire STROBE_TIME,              // sense sample strobe
	input wire [DW-1:0] SENSE_IN,        // sense amplifier outputs
	input wire MEM_DATA_DIRECTION_N,     // data direction, low drives bus
	input wire [DW-1:0] MEMORY_DATA_BUS_I, // bus level seen on the pins
	output wire [DW-1:0] MEMORY_DATA_BUS_O, // bus drive value
	output wire MEMORY_DATA_BUS_OE,      // bus output enable
	output wire [DW-1:0] INHIBIT_DRV,    // per-bit inhibit drivers
	output wire [7:0] READ_LINE_X,       // read x line selects
	output wire [7:0] READ_LINE_Y,       // read y line selects
	output wire [7:0] WRITE_LINE_X,      // write x line selects
	output wire [7:0] WRITE_LINE_Y,      // write y line selects
	output wire FIELD_HIT                // this field is addressed
);
	// ****************************************
	// pin synchronisers: three stages, change counts when 2nd and 3rd agree
	// ****************************************
	localparam NS = 3 + 1 + 12 + 6 + DW + 1 + DW;
	wire [NS-1:0] pins_raw;
	reg [NS-1:0] s1_q;
	reg [NS-1:0] s2_q;
	reg [NS-1:0] s3_q;
	reg [NS-1:0] pins_q;
	assign pins_raw = {EXT_ADDR_N, ROM_SPACE_N, MEM_ADDR_N, RETURN_PHASE, WRITE_ACTIVE,
		WRITE_EN, INHIBIT_TIME, STROBE_TIME, 1'b0, SENSE_IN, MEM_DATA_DIRECTION_N,
		MEMORY_DATA_BUS_I};
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			s1_q <= {NS{1'b0}};
			s2_q <= {NS{1'b0}};
			s3_q <= {NS{1'b0}};
			pins_q <= {NS{1'b0}};
		end else begin
			s1_q <= pins_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			pins_q <= (s2_q & s3_q) | (pins_q & (s2_q | s3_q));
		end
	end

	wire [DW-1:0] bus_in = pins_q[DW-1:0];
	wire dir_n = pins_q[DW];
	wire [DW-1:0] sense_s = pins_q[2*DW:DW+1];
	wire strobe_s = pins_q[2*DW+2];
	wire inhibit_s = pins_q[2*DW+3];
	wire wen_s = pins_q[2*DW+4];
	wire write_s = pins_q[2*DW+5];
	wire return_s = pins_q[2*DW+6];
	wire [11:0] addr_n = pins_q[2*DW+18:2*DW+7];
	wire rom_n = pins_q[2*DW+19];
	wire [2:0] ext_n = pins_q[2*DW+22:2*DW+20];

	// ****************************************
	// software registers
	// ****************************************
	reg [2:0] jumper_q;
	reg lock_q;
	reg [31:0] rdata_q;

	// ****************************************
	// field select
	// ****************************************
	// jumper in reads as zero bit, so all jumpers in compares against field zero
	wire field_match = (~ext_n == jumper_q); // R08 R09
	wire field_hit = field_match && rom_n; // R08
	assign FIELD_HIT = field_hit;

	// ****************************************
	// sense clear pulse
	// ****************************************
	localparam CW = 8;
	reg [CW-1:0] clr_cnt_q;
	reg clr_arm_q;
	wire clr_start = !write_s && return_s && clr_arm_q; // R14
	wire clearing = (clr_cnt_q != {CW{1'b0}});
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			clr_cnt_q <= {CW{1'b0}};
			clr_arm_q <= 1'b1;
		end else begin
			if (clr_start) begin
				clr_cnt_q <= CLEAR_CYC[CW-1:0]; // R14
			end else if (clearing) begin
				clr_cnt_q <= clr_cnt_q - 1'b1;
			end
			// one pulse per read portion: rearm once return drops or write starts
			if (clr_start) begin
				clr_arm_q <= 1'b0;
			end else if (write_s || !return_s) begin
				clr_arm_q <= 1'b1;
			end
		end
	end

	// ****************************************
	// sense flip-flops (memory data register)
	// ****************************************
	reg [DW-1:0] sense_q;
	reg strobe_d1_q;
	wire strobe_rise = strobe_s && !strobe_d1_q;
	wire time_strobe = strobe_rise && !write_s && field_hit && !clearing;
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			sense_q <= {DW{1'b0}};
			strobe_d1_q <= 1'b0;
		end else begin
			strobe_d1_q <= strobe_s;
			if (clr_start || clearing) begin
				sense_q <= {DW{1'b0}}; // R01 R14
			end else if (time_strobe) begin
				sense_q <= sense_q | sense_s; // R02
			end
		end
	end

	// ****************************************
	// memory data bus drive
	// ****************************************
	// direction pin reaches the bus enable through the synchroniser, so the
	// enable trails the pin by a few cycles; the processor holds it long enough
	assign MEMORY_DATA_BUS_O = sense_q; // R03 R13
	assign MEMORY_DATA_BUS_OE = !dir_n; // R03 R04

	// ****************************************
	// inhibit control and load gates
	// ****************************************
	// with the register driving, its own value is loaded in place of the bus pins (rewrite)
	wire [DW-1:0] load_bits = dir_n ? bus_in : sense_q; // R05 R04
	wire load_en = field_hit && inhibit_s && return_s && wen_s && !lock_q; // R06 R10 R15
	reg [DW-1:0] inh_q;
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			inh_q <= {DW{1'b0}};
		end else if (load_en) begin
			inh_q <= ~load_bits; // R07
		end else begin
			inh_q <= {DW{1'b0}};
		end
	end
	assign INHIBIT_DRV = inh_q;

	// ****************************************
	// x/y line selection
	// ****************************************
	// x from address bits 0-2, y from 6-8 (msb first); bit 0 is the msb
	wire [2:0] x_code = ~addr_n[11:9];
	wire [2:0] y_code = ~addr_n[5:3];
	wire read_en = field_hit && !write_s && return_s;
	wire write_en = field_hit && write_s;
	csi_line_decode u_rx (
		.code(x_code),
		.enable(read_en),
		.lines(READ_LINE_X), // R11
		.grp1(),
		.grp2()
	);
	csi_line_decode u_ry (
		.code(y_code),
		.enable(read_en),
		.lines(READ_LINE_Y), // R11
		.grp1(),
		.grp2()
	);
	csi_line_decode u_wx (
		.code(x_code),
		.enable(write_en),
		.lines(WRITE_LINE_X), // R12
		.grp1(),
		.grp2()
	);
	csi_line_decode u_wy (
		.code(y_code),
		.enable(write_en),
		.lines(WRITE_LINE_Y), // R12
		.grp1(),
		.grp2()
	);

	// ****************************************
	// apb slave, zero wait states
	// ****************************************
	wire wr_acc = PSEL && PENABLE && PWRITE;
	wire rd_setup = PSEL && !PENABLE && !PWRITE;
	wire addr_ok = (PADDR == `CSI_REG_CTRL) || (PADDR == `CSI_REG_STAT) ||
		(PADDR == `CSI_REG_DATA) || (PADDR == `CSI_REG_ADDR);
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			jumper_q <= `CSI_FIELD_JUMPERS; // R09
			lock_q <= 1'b0;
		end else if (wr_acc && PADDR == `CSI_REG_CTRL) begin
			jumper_q <= PWDATA[`CSI_CTRL_FIELD_LSB+2:`CSI_CTRL_FIELD_LSB];
			lock_q <= PWDATA[`CSI_CTRL_LOCK_BIT];
		end
	end
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			rdata_q <= 32'h0000_0000;
		end else if (rd_setup) begin
			case (PADDR)
			`CSI_REG_CTRL: begin
				rdata_q <= {28'h000_0000, lock_q, jumper_q};
			end
			`CSI_REG_STAT: begin
				rdata_q <= {27'h000_0000, lock_q, |inh_q, clearing, inhibit_s, field_hit};
			end
			`CSI_REG_DATA: begin
				rdata_q <= {{(32-DW){1'b0}}, sense_q};
			end
			`CSI_REG_ADDR: begin
				rdata_q <= {16'h0000, rom_n, ext_n, ~addr_n};
			end
			default: begin
				rdata_q <= 32'h0000_0000;
			end
			endcase
		end
	end
	assign PRDATA = rdata_q;
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !addr_ok;
endmodule

// file: sim/csi_timing_model.sv
`timescale 1ns/1ps
// ****
// timing generator and buffer register
// ****
module csi_timing_model (
	input wire clk, // clock
	input wire rstn, // reset, active low
	input wire start, // begin one memory cycle
	input wire [11:0] word, // core contents at the address
	input wire [11:0] buf_val, // buffer register value
	input wire dir_req_n, // direction wanted for this cycle
	output logic ret_ph, // return phase
	output logic wr_act, // write portion
	output logic wr_en, // write enable
	output logic inh_t, // inhibit timing
	output logic stb_t, // sense strobe
	output logic dir_n, // data direction, active low
	output logic [11:0] sense, // sense amplifier outputs
	output logic [11:0] bus_val, // level put on the bus by the processor
	output logic mid_r, // middle of read portion
	output logic mid_w, // middle of write portion
	output logic busy // cycle in progress
);
	logic [5:0] ph_q;
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			ph_q <= 6'h00;
		else if (ph_q != 0)
			ph_q <= (ph_q == 6'h28) ? 6'h00 : ph_q + 6'h01;
		else if (start)
			ph_q <= 6'h01;
	end
	assign busy = ph_q != 0;
	assign ret_ph = busy;
	assign wr_act = ph_q >= 6'h14;
	assign wr_en = wr_act;
	assign inh_t = ph_q >= 6'h18 && ph_q <= 6'h23;
	assign stb_t = ph_q >= 6'h0a && ph_q <= 6'h0d;
	// outside the strobe the amplifiers show the inverse of the word, never the held word
	assign sense = stb_t ? word : ~word;
	assign dir_n = busy ? dir_req_n : 1'b1;
	// with dir_n low the processor level is the inverse so a stale value cannot pass
	assign bus_val = dir_n ? buf_val : ~buf_val;
	assign mid_r = ph_q == 6'h10;
	assign mid_w = ph_q == 6'h22;
endmodule

// file: sim/csi_core_checker.sv
`timescale 1ns/1ps
module csi_core_checker (
	input wire CLK, // clock
	input wire RESETN, // reset, active low
	input wire PSEL, // apb select
	input wire PENABLE, // apb access phase
	input wire PSLVERR, // apb error
	input wire ROM_SPACE_N, // rom space, active low
	input wire INHIBIT_TIME, // inhibit timing
	input wire MEM_DATA_DIRECTION_N, // direction, active low
	input wire MEMORY_DATA_BUS_OE, // bus enable
	input wire [11:0] INHIBIT_DRV, // inhibit drivers
	input wire [7:0] READ_LINE_X, // read x
	input wire [7:0] READ_LINE_Y, // read y
	input wire [7:0] WRITE_LINE_X, // write x
	input wire [7:0] WRITE_LINE_Y, // write y
	input wire FIELD_HIT // field addressed
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);
	a_slverr_access: assert property (PSLVERR |-> PSEL && PENABLE) else $error("error out of access");
	a_rom_blocks_hit: assert property ((!ROM_SPACE_N) [*6] |-> !FIELD_HIT)
		else $error("hit in rom space");
	a_bus_release: assert property (MEM_DATA_DIRECTION_N [*6] |-> !MEMORY_DATA_BUS_OE)
		else $error("bus driven");
	a_bus_drive: assert property ((!MEM_DATA_DIRECTION_N) [*6] |-> MEMORY_DATA_BUS_OE)
		else $error("bus not driven");
	a_inh_timing: assert property ((!INHIBIT_TIME) [*8] |-> INHIBIT_DRV == 0)
		else $error("inhibit off time");
	a_inh_hit: assert property (|INHIBIT_DRV |-> $past(FIELD_HIT))
		else $error("inhibit without hit");
	a_read_onehot: assert property ($onehot0(READ_LINE_X) && $onehot0(READ_LINE_Y))
		else $error("read lines");
	a_read_pair: assert property ((READ_LINE_X != 0) == (READ_LINE_Y != 0))
		else $error("read pair");
	a_write_pair: assert property ($onehot0(WRITE_LINE_X) && $onehot0(WRITE_LINE_Y)
		&& (WRITE_LINE_X != 0) == (WRITE_LINE_Y != 0)) else $error("write pair");
	a_lines_hit: assert property ((READ_LINE_X | WRITE_LINE_X) != 0 |-> FIELD_HIT)
		else $error("lines without hit");
endmodule
bind csi_core csi_core_checker chk (.CLK, .RESETN, .PSEL, .PENABLE, .PSLVERR, .ROM_SPACE_N,
	.INHIBIT_TIME, .MEM_DATA_DIRECTION_N, .MEMORY_DATA_BUS_OE, .INHIBIT_DRV, .READ_LINE_X,
	.READ_LINE_Y, .WRITE_LINE_X, .WRITE_LINE_Y, .FIELD_HIT);

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {logic [2:0] x, y; logic [11:0] inh, dat; logic hit, dir;} csi_exp_t;
	logic CLK = 0, RESETN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, ROM_SPACE_N = 1;
	logic PREADY, PSLVERR, MEMORY_DATA_BUS_OE, FIELD_HIT, start = 0, dir = 0, busy, mid_r, mid_w, e;
	logic RETURN_PHASE, WRITE_ACTIVE, WRITE_EN, INHIBIT_TIME, STROBE_TIME, MEM_DATA_DIRECTION_N;
	logic [2:0] EXT_ADDR_N = 3'h7;
	logic [11:0] PADDR = 0, MEM_ADDR_N = 12'hfff, word = 0, bufv = 0, bus_val;
	logic [11:0] SENSE_IN, MEMORY_DATA_BUS_I, MEMORY_DATA_BUS_O, INHIBIT_DRV;
	logic [7:0] READ_LINE_X, READ_LINE_Y, WRITE_LINE_X, WRITE_LINE_Y;
	logic [31:0] PWDATA = 0, PRDATA, r, rv, seed = 32'h4b9f_e1eb;
	int bad_count = 0, tests_run = 0;
	csi_exp_t q[$], xe;
	always #5 CLK = ~CLK;
	assign MEMORY_DATA_BUS_I = MEMORY_DATA_BUS_OE ? MEMORY_DATA_BUS_O : bus_val;
	csi_core #(.CLEAR_CYC(5)) DUT (.CLK, .RESETN, .PADDR, .PSEL, .PENABLE, .PWRITE, .PWDATA,
		.PRDATA, .PREADY, .PSLVERR, .EXT_ADDR_N, .ROM_SPACE_N, .MEM_ADDR_N, .RETURN_PHASE,
		.WRITE_ACTIVE, .WRITE_EN, .INHIBIT_TIME, .STROBE_TIME, .SENSE_IN, .MEM_DATA_DIRECTION_N,
		.MEMORY_DATA_BUS_I, .MEMORY_DATA_BUS_O, .MEMORY_DATA_BUS_OE, .INHIBIT_DRV, .READ_LINE_X,
		.READ_LINE_Y, .WRITE_LINE_X, .WRITE_LINE_Y, .FIELD_HIT);
	csi_timing_model tm (.clk(CLK), .rstn(RESETN), .start, .word, .buf_val(bufv),
		.dir_req_n(dir), .ret_ph(RETURN_PHASE), .wr_act(WRITE_ACTIVE), .wr_en(WRITE_EN),
		.inh_t(INHIBIT_TIME), .stb_t(STROBE_TIME), .dir_n(MEM_DATA_DIRECTION_N),
		.sense(SENSE_IN), .bus_val, .mid_r, .mid_w, .busy);
	task chk(input string n, input logic [31:0] s, input logic [31:0] x);
		tests_run++;
		if (s !== x) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, x, s);
		end
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1; PWRITE <= w; PADDR <= a; PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1;
		do @(posedge CLK); while (PREADY !== 1'b1);
		r = PRDATA; e = PSLVERR; PSEL <= 0; PENABLE <= 0;
	endtask
	always @(negedge CLK) begin
		if (mid_r) begin
			chk("rx", READ_LINE_X, q[0].hit ? 8'h01 << q[0].x : 8'h00);
			chk("ry", READ_LINE_Y, q[0].hit ? 8'h01 << q[0].y : 8'h00);
		end
		if (mid_w) begin
			xe = q.pop_front();
			chk("inh", INHIBIT_DRV, xe.inh);
			chk("wx", WRITE_LINE_X, xe.hit ? 8'h01 << xe.x : 8'h00);
			chk("wy", WRITE_LINE_Y, xe.hit ? 8'h01 << xe.y : 8'h00);
			chk("oe", MEMORY_DATA_BUS_OE, !xe.dir);
			if (!xe.dir && xe.hit) chk("bus", MEMORY_DATA_BUS_O, xe.dat);
		end
	end
	initial begin
		#200000;
		bad_count++;
		summarize;
	end
	initial begin
		repeat (2) @(posedge CLK);
		RESETN <= 1;
		apb(0, 12'h000, 0);
		chk("jumpers", r, 0);
		repeat (8) @(posedge CLK);
		chk("hit0", FIELD_HIT, 1);
		// ****
		// field compare: match, rom space, one bit off
		// ****
		for (int f = 0; f < 8; f++) for (int k = 0; k < 3; k++) begin
			apb(1, 12'h000, f);
			ROM_SPACE_N <= k != 1;
			EXT_ADDR_N <= ~(f[2:0] ^ {2'h0, k == 2});
			repeat (8) @(posedge CLK);
			chk("hit", FIELD_HIT, k == 0);
		end
		apb(0, 12'h010, 0);
		chk("slverr", e, 1);
		chk("unmapped", r, 0);
		$display("test fields done");
		// ****
		// memory cycles: every line code, restore and buffer writes
		// ****
		for (int i = 0; i < 24; i++) begin
			rv = $random(seed);
			apb(1, 12'h000, {29'h0, rv[2:0]});
			EXT_ADDR_N <= (rv[3] | rv[4]) ? ~rv[2:0] : ~(rv[2:0] ^ 3'h5);
			MEM_ADDR_N <= {~i[2:0], rv[8:6], i[2:0], rv[11:9]};
			word <= rv[17:6]; bufv <= rv[29:18]; dir <= rv[5];
			q.push_back({i[2:0], ~i[2:0], (rv[3] | rv[4]) ? ~(rv[5] ? rv[29:18] : rv[17:6])
				: 12'h000, rv[17:6], rv[3] | rv[4], rv[5]});
			repeat (8) @(posedge CLK);
			start <= 1;
			@(posedge CLK);
			start <= 0;
			@(posedge CLK);
			while (busy) @(posedge CLK);
			apb(0, 12'h008, 0);
			if (rv[3] | rv[4]) chk("data", r, rv[17:6]);
		end
		$display("test memory cycles done");
		summarize;
	end
endmodule
